// ### cibk_consts.svh
// constants for the charger interrupt flag and mask bank
`ifndef CIBK_CONSTS_SVH
`define CIBK_CONSTS_SVH

// register offsets
`define CIBK_OFS_FLAG_FIVE 8'h27
`define CIBK_OFS_MASK_ZERO 8'h28
`define CIBK_OFS_MASK_ONE 8'h29
`define CIBK_OFS_MASK_TWO 8'h2a
`define CIBK_OFS_MASK_THREE 8'h2b
`define CIBK_OFS_MASK_FOUR 8'h2c
`define CIBK_OFS_MASK_FIVE 8'h2d

// flag five bit positions
`define CIBK_BIT_SYS_RAIL_LOW 7
`define CIBK_BIT_SYS_RAIL_HIGH 6
`define CIBK_BIT_SOURCE_OUT_HIGH 5
`define CIBK_BIT_SOURCE_OUT_LOW 4
`define CIBK_BIT_THERMAL_SHUTDOWN 2

// implemented (writable or settable) bits per register
`define CIBK_USED_FLAG_FIVE 8'hf4
`define CIBK_WMASK_ZERO 8'hff
`define CIBK_WMASK_ONE 8'hd7
`define CIBK_WMASK_TWO 8'h7f
`define CIBK_WMASK_THREE 8'h1f
`define CIBK_WMASK_FOUR 8'hff
`define CIBK_WMASK_FIVE 8'hf4

// reset values
`define CIBK_RST_FLAG 8'h00
`define CIBK_RST_MASK 8'h00

// masks that also clear on a watchdog reset, one bit per mask register
`define CIBK_MASK_CLR_ON_WDT 6'h08

// read data for an unmapped offset
`define CIBK_UNMAPPED_DATA 8'h00

`endif

// ### cibk_pkg.sv
// types shared by the charger interrupt bank
`default_nettype none
package cibk_pkg;
	typedef logic [7:0] cibk_byte_t;
	typedef logic [5:0][7:0] cibk_mask_bank_t;
endpackage : cibk_pkg
`default_nettype wire

// ### cibk_flag_reg.sv
// sticky read-to-clear event flag register
`default_nettype none
module cibk_flag_reg #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] USED = '1,
	parameter logic [WIDTH-1:0] ANY_EDGE = '0,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] status,
	input wire logic rdClr,
	output logic [WIDTH-1:0] flags
);
	logic [WIDTH-1:0] prev_r;
	logic primed_r;
	logic [WIDTH-1:0] flags_r;
	logic [WIDTH-1:0] evt;

	// ************************************************
	// edge detection, one cell per bit
	// ************************************************
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			// rising edge, or any change for level-type sources
			assign evt[gi] = USED[gi] & primed_r &
				(ANY_EDGE[gi] ? (status[gi] ^ prev_r[gi]) : (status[gi] & ~prev_r[gi]));
		end
	endgenerate

	// status history; first sample after reset only primes it
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= '0;
			primed_r <= 1'b0;
		end else if (ce) begin
			prev_r <= status;
			primed_r <= 1'b1;
		end
	end

	// sticky flags: a read clears, a new event in the same cycle wins
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= RST_VAL;
		end else if (ce) begin
			flags_r <= ((rdClr ? '0 : flags_r) | evt) & USED;
		end
	end

	assign flags = flags_r;
endmodule : cibk_flag_reg
`default_nettype wire

// ### cibk_mask_reg.sv
// one interrupt mask register with reset-source selection
`default_nettype none
module cibk_mask_reg #(
	parameter logic [7:0] WMASK = 8'hff,
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter bit CLR_ON_WDT = 1'b0
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic [7:0] wrData,
	input wire logic regRst,
	input wire logic wdtRst,
	output logic [7:0] value
);
	logic [7:0] value_r;

	// soft resets take priority over a write in the same cycle
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			value_r <= RST_VAL;
		end else if (ce) begin
			if (regRst || (CLR_ON_WDT && wdtRst)) begin
				value_r <= RST_VAL;
			end else if (wrEn) begin
				value_r <= wrData & WMASK;
			end
		end
	end

	assign value = value_r;
endmodule : cibk_mask_reg
`default_nettype wire

// ### cibk_irq_bank.sv
// charger interrupt flag five register, six mask registers and request output
`include "cibk_consts.svh"
`default_nettype none
// Functional notes
// - flag bit 7 sets on system rail undervoltage rise, clears on read
// - flag bit 6 sets on system rail overvoltage rise, clears on read
// - flag bit 5 sets on source output overvoltage rise, clears on read
// - flag bit 4 sets on source output undervoltage rise, clears on read
// - flag bit 2 sets on thermal shutdown rise, clears on read
// - flag five is zero at power-up, untouched by watchdog or register reset
// - mask bits reset to zero; one blocks the request, zero allows it
// - mask zero covers the eight input supply events, bits 7 to 0
// - mask one covers charge, optimiser, input, thermal reg, battery, port detect
// - mask two covers dataline, conversion, min system and four timer events
// - mask three bits 3 to 0 cover four temperature zones, 7 to 5 reserved
// - mask three bit 4 low battery; mask three also clears on watchdog
// - mask four covers battery current, overvoltage and overcurrent events
// - masks zero, one, two, four clear on register reset only
// - all flag five sources are rising-edge type (ANY_EDGE clear); cleared on read
module cibk_irq_bank (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	input wire cibk_pkg::cibk_byte_t regAddr,
	input wire logic regWrEn,
	input wire cibk_pkg::cibk_byte_t regWrData,
	input wire logic regRdEn,
	output cibk_pkg::cibk_byte_t regRdData,
	output logic regRdValid,
	input wire logic regResetPulse,
	input wire logic watchdogTriggeredReset,
	input wire logic sysRailLowStatus,
	input wire logic sysRailHighStatus,
	input wire logic sourceOutHighStatus,
	input wire logic sourceOutLowStatus,
	input wire logic thermalShutdownStatus,
	input wire cibk_pkg::cibk_byte_t flagsZero,
	input wire cibk_pkg::cibk_byte_t flagsOne,
	input wire cibk_pkg::cibk_byte_t flagsTwo,
	input wire cibk_pkg::cibk_byte_t flagsThree,
	input wire cibk_pkg::cibk_byte_t flagsFour,
	output cibk_pkg::cibk_byte_t flagsFive,
	output cibk_pkg::cibk_mask_bank_t masks,
	output logic irqReq
);
	import cibk_pkg::*;

	// ************************************************
	// constant tables
	// ************************************************
	localparam cibk_mask_bank_t MASK_WMASK = {
		`CIBK_WMASK_FIVE, `CIBK_WMASK_FOUR, `CIBK_WMASK_THREE,
		`CIBK_WMASK_TWO, `CIBK_WMASK_ONE, `CIBK_WMASK_ZERO
	};
	localparam cibk_mask_bank_t MASK_OFS = {
		`CIBK_OFS_MASK_FIVE, `CIBK_OFS_MASK_FOUR, `CIBK_OFS_MASK_THREE,
		`CIBK_OFS_MASK_TWO, `CIBK_OFS_MASK_ONE, `CIBK_OFS_MASK_ZERO
	};
	localparam logic [5:0] MASK_CLR_WDT = `CIBK_MASK_CLR_ON_WDT;

	cibk_byte_t statusFive;
	cibk_byte_t flagsFiveVal;
	cibk_mask_bank_t maskVal;
	cibk_mask_bank_t flagBank;
	logic [5:0] maskWrSel;
	logic flagRdClr;
	cibk_byte_t rdMux;
	cibk_byte_t rdData_r;
	logic rdValid_r;
	logic irq_r;

	// ************************************************
	// flag five: status sources to sticky flags
	// ************************************************
	always_comb begin
		statusFive = 8'h00;
		statusFive[`CIBK_BIT_SYS_RAIL_LOW] = sysRailLowStatus;
		statusFive[`CIBK_BIT_SYS_RAIL_HIGH] = sysRailHighStatus;
		statusFive[`CIBK_BIT_SOURCE_OUT_HIGH] = sourceOutHighStatus;
		statusFive[`CIBK_BIT_SOURCE_OUT_LOW] = sourceOutLowStatus;
		statusFive[`CIBK_BIT_THERMAL_SHUTDOWN] = thermalShutdownStatus;
	end

	// a host read of the flag register clears it after the value is captured
	assign flagRdClr = regRdEn && (regAddr == `CIBK_OFS_FLAG_FIVE);

	// soft resets are not wired here: flag five keeps its value through them
	cibk_flag_reg #(
		.WIDTH(8),
		.USED(`CIBK_USED_FLAG_FIVE),
		.ANY_EDGE(8'h00),
		.RST_VAL(`CIBK_RST_FLAG)
	) u_flag_five (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ce(ce),
		.status(statusFive),
		.rdClr(flagRdClr),
		.flags(flagsFiveVal)
	);

	// ************************************************
	// mask registers
	// ************************************************
	genvar gm;
	generate
		for (gm = 0; gm < 6; gm++) begin : g_mask
			// write strobe per mask register
			assign maskWrSel[gm] = regWrEn && (regAddr == MASK_OFS[gm]);
			// bit maps follow the flag registers one to one
			cibk_mask_reg #(
				.WMASK(MASK_WMASK[gm]),
				.RST_VAL(`CIBK_RST_MASK),
				.CLR_ON_WDT(MASK_CLR_WDT[gm])
			) u_mask (
				.clk_sys(clk_sys),
				.arst_n(arst_n),
				.ce(ce),
				.wrEn(maskWrSel[gm]),
				.wrData(regWrData),
				.regRst(regResetPulse),
				.wdtRst(watchdogTriggeredReset),
				.value(maskVal[gm])
			);
		end
	endgenerate

	// ************************************************
	// register read port
	// ************************************************
	always_comb begin
		rdMux = `CIBK_UNMAPPED_DATA;
		unique case (regAddr)
			`CIBK_OFS_FLAG_FIVE: rdMux = flagsFiveVal;
			`CIBK_OFS_MASK_ZERO: rdMux = maskVal[0];
			`CIBK_OFS_MASK_ONE: rdMux = maskVal[1];
			`CIBK_OFS_MASK_TWO: rdMux = maskVal[2];
			`CIBK_OFS_MASK_THREE: rdMux = maskVal[3];
			`CIBK_OFS_MASK_FOUR: rdMux = maskVal[4];
			`CIBK_OFS_MASK_FIVE: rdMux = maskVal[5];
			default: rdMux = `CIBK_UNMAPPED_DATA;
		endcase
	end

	// read data captured one cycle after the strobe, held until the next read
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rdData_r <= 8'h00;
			rdValid_r <= 1'b0;
		end else if (ce) begin
			rdValid_r <= regRdEn;
			if (regRdEn) begin
				rdData_r <= rdMux;
			end
		end
	end

	// ************************************************
	// interrupt request
	// ************************************************
	assign flagBank = {flagsFiveVal, flagsFour, flagsThree, flagsTwo, flagsOne, flagsZero};

	// any set flag in an implemented bit whose mask is clear raises the request
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_r <= |(flagBank & ~maskVal & MASK_WMASK);
		end
	end

	assign regRdData = rdData_r;
	assign regRdValid = rdValid_r;
	assign flagsFive = flagsFiveVal;
	assign masks = maskVal;
	assign irqReq = irq_r;
endmodule : cibk_irq_bank
`default_nettype wire

// ### cibk_irq_bank_sva.sv
// concurrent checks on the ports of the charger interrupt bank
`include "cibk_consts.svh"
`default_nettype none
module cibk_irq_bank_sva (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire cibk_pkg::cibk_byte_t regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire cibk_pkg::cibk_byte_t regRdData,
	input wire logic regRdValid,
	input wire logic regResetPulse,
	input wire logic watchdogTriggeredReset,
	input wire logic sysRailLowStatus,
	input wire cibk_pkg::cibk_byte_t flagsZero,
	input wire cibk_pkg::cibk_byte_t flagsOne,
	input wire cibk_pkg::cibk_byte_t flagsTwo,
	input wire cibk_pkg::cibk_byte_t flagsThree,
	input wire cibk_pkg::cibk_byte_t flagsFour,
	input wire cibk_pkg::cibk_byte_t flagsFive,
	input wire cibk_pkg::cibk_mask_bank_t masks,
	input wire logic irqReq
);
	timeunit 1ns;
	timeprecision 1ns;
	import cibk_pkg::*;
	// ************************************************************
	// request cause and read decode
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic rdFlag;
	logic irqCause;
	assign rdFlag = regRdEn && regAddr == `CIBK_OFS_FLAG_FIVE;
	assign irqCause = |(flagsFive & ~masks[5]) | |(flagsZero & ~masks[0])
		| |(flagsOne & ~masks[1] & 8'hd7) | |(flagsTwo & ~masks[2] & 8'h7f)
		| |(flagsThree & ~masks[3] & 8'h1f) | |(flagsFour & ~masks[4]);
	property p_set7; $past(arst_n) && $rose(sysRailLowStatus) |=> flagsFive[7]; endproperty
	a_set7: assert property (p_set7) else $error("flag seven not set");
	property p_clr; rdFlag && $stable(sysRailLowStatus) |=> !flagsFive[7]; endproperty
	a_clr: assert property (p_clr) else $error("flag seven not cleared");
	property p_rd; rdFlag |=> regRdValid && regRdData == $past(flagsFive); endproperty
	a_rd: assert property (p_rd) else $error("flag read data wrong");
	property p_rsvd; (flagsFive & 8'h0b) == 8'h00 && (masks[1] & 8'h28) == 8'h00
		&& masks[2][7] == 1'b0 && masks[3][7:5] == 3'h0 && (masks[5] & 8'h0b) == 8'h00; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_irq; $past(arst_n) |-> irqReq == $past(irqCause); endproperty
	a_irq: assert property (p_irq) else $error("request level wrong");
	property p_wdt; watchdogTriggeredReset |=> masks[3] == 8'h00; endproperty
	a_wdt: assert property (p_wdt) else $error("mask three kept on watchdog");
	property p_wdt_keep; watchdogTriggeredReset && !regResetPulse && !regWrEn
		|=> $stable(masks[2:0]) && $stable(masks[5:4]); endproperty
	a_wdt_keep: assert property (p_wdt_keep) else $error("mask lost on watchdog");
	property p_regrst; regResetPulse |=> masks == '0; endproperty
	a_regrst: assert property (p_regrst) else $error("mask kept on reg reset");
endmodule : cibk_irq_bank_sva
`default_nettype wire

// ### cibk_flag_src.sv
// model of the other flag registers that feed the request
`default_nettype none
module cibk_flag_src (
	input wire logic clk_sys,
	input wire logic [2:0] selIdx,
	input wire logic [7:0] setVal,
	output logic [4:0][7:0] flagsOut
);
	timeunit 1ns;
	timeprecision 1ns;
	// one flag byte carries the pattern, the others stay clear
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 5; i++) begin
			flagsOut[i] <= (i == selIdx) ? setVal : 8'h00;
		end
	end
endmodule : cibk_flag_src
`default_nettype wire

// ### charger_irq_flag_mask_bank_tb.sv
// self-checking testbench for the charger interrupt bank
`include "cibk_consts.svh"
`default_nettype none
module charger_irq_flag_mask_bank_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cibk_pkg::*;
	typedef struct {cibk_byte_t a; cibk_byte_t d; cibk_byte_t e;} cibk_row_s;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic regWrEn = 1'b0, regRdEn = 1'b0, regRst = 1'b0, wdtRst = 1'b0, regRdValid, irqReq;
	cibk_byte_t regAddr = 8'h00, regWrData = 8'h00, setVal = 8'h00, regRdData, flagsFive, rdVal;
	logic [4:0] stat = 5'h00;
	logic [2:0] selIdx = 3'h0;
	logic [4:0][7:0] srcFlags;
	cibk_mask_bank_t masks;
	int n_fail = 0, check_count = 0;
	cibk_row_s rows[8] = '{'{8'h28, 8'ha5, 8'ha5}, '{8'h29, 8'hff, 8'hd7}, '{8'h2a, 8'hff, 8'h7f},
		'{8'h2b, 8'hff, 8'h1f}, '{8'h2c, 8'hff, 8'hff}, '{8'h2d, 8'hff, 8'hf4},
		'{8'h27, 8'hff, 8'h00}, '{8'h2e, 8'hff, 8'h00}};
	int pos[5] = '{2, 4, 5, 6, 7};
	always #25 clk_sys = ~clk_sys;
	cibk_irq_bank dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .regResetPulse(regRst), .watchdogTriggeredReset(wdtRst),
		.sysRailLowStatus(stat[4]), .sysRailHighStatus(stat[3]), .sourceOutHighStatus(stat[2]),
		.sourceOutLowStatus(stat[1]), .thermalShutdownStatus(stat[0]), .flagsZero(srcFlags[0]),
		.flagsOne(srcFlags[1]), .flagsTwo(srcFlags[2]), .flagsThree(srcFlags[3]),
		.flagsFour(srcFlags[4]), .flagsFive(flagsFive), .masks(masks), .irqReq(irqReq));
	cibk_flag_src u_src (.clk_sys(clk_sys), .selIdx(selIdx), .setVal(setVal), .flagsOut(srcFlags));
	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input string nm, input cibk_byte_t exp, input cibk_byte_t got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step
	task automatic wr(input cibk_byte_t a, input cibk_byte_t d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		step(1);
		regWrEn = 1'b0;
	endtask : wr
	task automatic rd(input cibk_byte_t a);
		regAddr = a;
		regRdEn = 1'b1;
		step(1);
		regRdEn = 1'b0;
		rdVal = regRdData;
		chk("rdValid", 8'h01, {7'h00, regRdValid});
	endtask : rd
	task automatic report_and_stop;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		step(8);
		arst_n = 1'b1;
		chk("flagsFive", 8'h00, flagsFive);
		for (int i = 0; i < 6; i++) chk("mask", 8'h00, masks[i]);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk("reg", rows[i].e, rdVal);
		end
		wdtRst = 1'b1;
		step(1);
		wdtRst = 1'b0;
		chk("mask3", 8'h00, masks[3]);
		chk("mask0", 8'ha5, masks[0]);
		chk("mask4", 8'hff, masks[4]);
		stat[0] = 1'b1;
		step(3);
		chk("flagsFive", 8'h04, flagsFive);
		chk("irq", 8'h00, {7'h00, irqReq});
		regRst = 1'b1;
		step(1);
		regRst = 1'b0;
		for (int i = 0; i < 6; i++) chk("mask", 8'h00, masks[i]);
		chk("flagsFive", 8'h04, flagsFive);
		step(1);
		chk("irq", 8'h01, {7'h00, irqReq});
		rd(8'h27);
		chk("rd27", 8'h04, rdVal);
		stat[0] = 1'b0;
		for (int i = 4; i >= 0; i--) begin
			step(1);
			stat[i] = 1'b1;
			step(2);
			chk("flagsFive", 8'h01 << pos[i], flagsFive);
			chk("irq", 8'h01, {7'h00, irqReq});
			rd(8'h27);
			chk("rd27", 8'h01 << pos[i], rdVal);
			stat[i] = 1'b0;
			step(2);
			chk("flagsFive", 8'h00, flagsFive);
			chk("irq", 8'h00, {7'h00, irqReq});
		end
		selIdx = 3'h1;
		setVal = 8'h28;
		step(3);
		chk("irq", 8'h00, {7'h00, irqReq});
		setVal = 8'h01;
		step(3);
		chk("irq", 8'h01, {7'h00, irqReq});
		wr(8'h29, 8'h01);
		step(2);
		chk("irq", 8'h00, {7'h00, irqReq});
		// a write while the clock enable is low must be lost
		ce = 1'b0;
		wr(8'h2c, 8'hff);
		step(1);
		chk("maskFrozen", 8'h00, masks[4]);
		ce = 1'b1;
		report_and_stop();
	end
	// hang guard
	initial begin
		#100us;
		n_fail++;
		report_and_stop();
	end
endmodule : charger_irq_flag_mask_bank_tb
bind cibk_irq_bank cibk_irq_bank_sva u_sva (.clk_sys, .arst_n, .regAddr, .regWrEn, .regRdEn,
	.regRdData, .regRdValid, .regResetPulse, .watchdogTriggeredReset, .sysRailLowStatus,
	.flagsZero, .flagsOne, .flagsTwo, .flagsThree, .flagsFour, .flagsFive, .masks, .irqReq);
`default_nettype wire
